// File: sensor_param_pkg.sv
// Constants, types and helper functions shared by the parameter bank
// Assumes a 32-bit APB register bus with byte addresses on 8 bits
package sensor_param_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_A     = 8'h00;
    localparam logic [7:0] RATELAT_A = 8'h04;
    localparam logic [7:0] SENSRNG_A = 8'h08;
    localparam logic [7:0] FLUSH_A   = 8'h0c;
    localparam logic [7:0] INFO0_A   = 8'h10;
    localparam logic [7:0] INFO1_A   = 8'h14;
    localparam logic [7:0] INFO2_A   = 8'h18;
    localparam logic [7:0] INFO3_A   = 8'h1c;
    localparam logic [7:0] INFO4_A   = 8'h20;
    localparam logic [7:0] STATUS_A  = 8'h24;

    // ------------------------------------------------------------
    // Field codes and positions
    // ------------------------------------------------------------
    localparam logic [7:0]  FLUSH_NOP       = 8'h00;
    localparam logic [7:0]  FLUSH_ALL       = 8'hff;
    localparam int          WAKE_BIT        = 5;
    localparam logic [15:0] RESERVED_EVENTS = 16'h0000;
    localparam logic [1:0]  PM_ABSENT       = 2'h0;
    localparam logic [1:0]  PM_STANDBY      = 2'h1;
    localparam logic [1:0]  PM_LOW_POWER    = 2'h2;
    localparam logic [1:0]  PM_HIGH_POWER   = 2'h3;
    localparam logic [15:0] RATE_TOP_POW2   = 16'h8000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        DT_QUAT, DT_VEC, DT_VEC_UNCAL, DT_ABS, DT_ABS_SHORT,
        DT_ABS_LONG, DT_EVENT, DT_ACTIVITY
    } dtype_t;

    typedef enum logic {FL_IDLE, FL_DRAIN} flush_st_t;

    // Output format of each sensor kind
    function automatic dtype_t kind_type(input logic [4:0] k);
        unique case (k)
            5'd1, 5'd2, 5'd3, 5'd4, 5'd9, 5'd10: kind_type = DT_VEC;
            5'd11, 5'd15, 5'd20:                 kind_type = DT_QUAT;
            5'd14, 5'd16:                        kind_type = DT_VEC_UNCAL;
            5'd6:                                kind_type = DT_ABS_LONG;
            5'd21:                               kind_type = DT_ABS_SHORT;
            5'd17, 5'd18, 5'd22, 5'd23, 5'd24,
            5'd25:                               kind_type = DT_EVENT;
            5'd31:                               kind_type = DT_ACTIVITY;
            default:                             kind_type = DT_ABS;
        endcase
    endfunction

    // Bytes per FIFO sample, one id byte included
    function automatic logic [7:0] sample_bytes(input dtype_t t);
        unique case (t)
            DT_QUAT:      sample_bytes = 8'h0b; // 4 x s16 + s16 accuracy
            DT_VEC:       sample_bytes = 8'h08; // 3 x s16 + status
            DT_VEC_UNCAL: sample_bytes = 8'h0e;
            DT_ABS:       sample_bytes = 8'h03;
            DT_ABS_SHORT: sample_bytes = 8'h02;
            DT_ABS_LONG:  sample_bytes = 8'h04;
            DT_EVENT:     sample_bytes = 8'h01;
            DT_ACTIVITY:  sample_bytes = 8'h03;
        endcase
    endfunction

endpackage

// File: cfg_mem_if.sv
// Port bundle between the parameter bank and its config memory
// Assumes one write port and one registered read port
`timescale 1ns/1ns
interface cfg_mem_if #(
    parameter int AW = 6,
    parameter int DW = 64
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctrl (output we, waddr, wdata, raddr, input rdata);
    modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// File: cfg_mem.sv
// Per-sensor rate, latency, sensitivity and range store
// Assumes a synchronous active-low reset that clears every word
`timescale 1ns/1ns
module cfg_mem #(
    parameter int AW = 6,
    parameter int DW = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Access port
    cfg_mem_if.mem   bus
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rd_q;

    // Clearing on reset keeps never-written sensors reading zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= '0;
            end
            rd_q <= '0;
        end else begin
            if (bus.we) begin
                mem_q[bus.waddr] <= bus.wdata;
            end
            rd_q <= mem_q[bus.raddr];
        end
    end

    assign bus.rdata = rd_q;
endmodule

// File: sensor_param_bank.sv
// Per-sensor parameter bank: configuration, info, status, flush
// Assumes an APB master on CLK and a FIFO engine that owns the samples
// Operation
// - Rate is unsigned 16-bit hertz; zero disables the sensor
// - Rate kept separately for wakeup and non-wakeup instances
// - Latency unsigned 16-bit ms; zero non-batched, nonzero batched
// - Latency kept separately for wakeup and non-wakeup instances
// - One id bit marks wakeup; ids above 32 are wakeup
// - Accept unsigned 16-bit change sensitivity per sensor
// - Accept unsigned 16-bit dynamic range per sensor
// - Rate and latency travel together in one eight-byte write
// - Read-back gives applied rate, 90 to 210 percent of request
// - Absent sensor reads back zero rate and latency
// - Applied period at most requested, at least half of it
// - Flush drains batched samples, then queues a completion event
// - Flush requested through one 8-bit register holding sensor id
// - Only wakeup sensors interrupt: per sample or on latency expiry
// - Wakeup and non-wakeup data go to separate FIFOs
// - Info holds type, driver id, version, range, resolution, rates
// - Reserved count reads zero; max count is FIFO bytes per sample
// - Fifteen info bytes readable along with per-sample size
// - 8-bit status: five flags plus a two-bit power mode
// - Absent sensor reads zero info and zero power mode
// - Scalars: s16, u16, u8 short and u24 long encodings
// - Uncalibrated vectors: three axes, three biases, accuracy
// - All-ones flush code flushes both FIFOs; zero does nothing
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module sensor_param_bank #(
    parameter logic [31:0] PRESENT_MASK = 32'h81ff_fffe,
    parameter logic [7:0]  DRIVER_ID    = 8'h01, // arbitrary value
    parameter logic [7:0]  DRIVER_VER   = 8'h01, // arbitrary value
    parameter logic [7:0]  POWER_TENTHS = 8'h0a,
    parameter logic [15:0] RESOLUTION   = 16'h0010,
    parameter logic [15:0] MAX_RATE     = 16'h0190,
    parameter logic [7:0]  MIN_RATE     = 8'h01,
    parameter logic [15:0] FIFO_BYTES   = 16'h1000,
    parameter logic [15:0] LP_RATE_MAX  = 16'h0032
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Sample events from the sensor engine
    input  wire logic        SMP_VALID,
    input  wire logic [5:0]  SMP_ID,
    input  wire logic        EXPIRE_VALID,
    input  wire logic [5:0]  EXPIRE_ID,
    output logic             WAKE_PUSH,
    output logic             NWAKE_PUSH,
    output logic             HOST_WAKE_REQ,
    // Status flag events
    input  wire logic        STAT_VALID,
    input  wire logic [5:0]  STAT_ID,
    input  wire logic [4:0]  STAT_SET,
    // Flush handshake with the FIFO engine
    output logic             FLUSH_REQ,
    output logic      [7:0]  FLUSH_ID,
    output logic             FLUSH_WAKE,
    output logic             FLUSH_NWAKE,
    input  wire logic        FLUSH_DONE,
    output logic             META_VALID,
    output logic      [7:0]  META_ID
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                   sel;
        logic [31:0]                  stage;
        logic [7:0]                   flush;
        sensor_param_pkg::flush_st_t  fst;
        logic                         fwake;
        logic                         fnwake;
        logic [63:0]                  en;
        logic [63:0]                  bat;
        logic [63:0][4:0]             flg;
        logic [31:0]                  rdata;
        logic                         err;
        logic                         wpush;
        logic                         npush;
        logic                         irq;
        logic                         meta;
        logic [7:0]                   meta_id;
    } state_t;

    state_t s_q;
    state_t s_d;

    cfg_mem_if #(.AW(6), .DW(64)) mbus ();

    cfg_mem #(.AW(6), .DW(64)) u_mem (
        .clk   (CLK),
        .rst_n (RST_N),
        .bus   (mbus)
    );

    // ------------------------------------------------------------
    // Decode of the selected sensor
    // ------------------------------------------------------------
    logic        setup;
    logic        wr;
    logic [4:0]  kind;
    logic        present;
    logic [15:0] req_rate;
    logic [15:0] req_lat;
    logic [15:0] act;
    logic [1:0]  pm;
    logic [7:0]  sbytes;
    logic [15:0] fifo_max;
    logic        commit;
    logic        mapped;

    assign setup  = PSEL && !PENABLE;
    assign wr     = PSEL && PENABLE && PWRITE;
    assign kind   = s_q.sel[4:0];
    // Id 0 and 32 name no sensor; bits above 5 are out of range
    assign present = (s_q.sel[7:6] == 2'b00) && (kind != 5'd0)
                     && PRESENT_MASK[kind];
    assign req_rate = mbus.rdata[15:0];
    assign req_lat  = mbus.rdata[31:16];
    assign commit   = wr && (PADDR == sensor_param_pkg::SENSRNG_A);
    assign sbytes   = sensor_param_pkg::sample_bytes(
                          sensor_param_pkg::kind_type(kind));
    // Constant per kind, so the divider folds to a small table
    assign fifo_max = FIFO_BYTES / {8'h00, sbytes};

    // Rounding up to a power of two keeps rate within 1x..2x
    function automatic logic [15:0] applied_rate(input logic [15:0] r);
        logic [15:0] p;
        p = 16'h0001;
        if (r == 16'h0000 || r > sensor_param_pkg::RATE_TOP_POW2) begin
            applied_rate = r;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (p < r) begin
                    p = {p[14:0], 1'b0};
                end
            end
            applied_rate = p;
        end
    endfunction

    assign act = applied_rate(req_rate);

    // Power mode derived from presence and programmed rate
    always_comb begin
        if (!present) begin
            pm = sensor_param_pkg::PM_ABSENT;
        end else if (req_rate == 16'h0000) begin
            pm = sensor_param_pkg::PM_STANDBY;
        end else if (req_rate <= LP_RATE_MAX) begin
            pm = sensor_param_pkg::PM_LOW_POWER;
        end else begin
            pm = sensor_param_pkg::PM_HIGH_POWER;
        end
    end

    // ------------------------------------------------------------
    // Config memory port
    // ------------------------------------------------------------
    // Staged rate/latency and this word form one 8-byte record
    assign mbus.we    = commit && present;
    assign mbus.waddr = s_q.sel[5:0];
    assign mbus.wdata = {PWDATA, s_q.stage};
    assign mbus.raddr = s_q.sel[5:0];

    always_comb begin
        unique case (PADDR)
            sensor_param_pkg::SEL_A,     sensor_param_pkg::RATELAT_A,
            sensor_param_pkg::SENSRNG_A, sensor_param_pkg::FLUSH_A,
            sensor_param_pkg::INFO0_A,   sensor_param_pkg::INFO1_A,
            sensor_param_pkg::INFO2_A,   sensor_param_pkg::INFO3_A,
            sensor_param_pkg::INFO4_A,   sensor_param_pkg::STATUS_A:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.wpush = 1'b0;
        s_d.npush = 1'b0;
        s_d.irq   = 1'b0;
        s_d.meta  = 1'b0;

        // Read data is latched in setup so it comes from a flop
        if (setup) begin
            s_d.err   = !mapped;
            s_d.rdata = 32'h0000_0000;
            unique case (PADDR)
                sensor_param_pkg::SEL_A:
                    s_d.rdata = {24'h00_0000, s_q.sel};
                sensor_param_pkg::RATELAT_A:
                    if (present) begin
                        s_d.rdata = {req_lat, act};
                    end // Absent reads zero
                sensor_param_pkg::SENSRNG_A:
                    if (present) begin
                        s_d.rdata = mbus.rdata[63:32];
                    end
                sensor_param_pkg::FLUSH_A:
                    s_d.rdata = {24'h00_0000, s_q.flush};
                sensor_param_pkg::INFO0_A:
                    if (present) begin
                        s_d.rdata = {8'h00, DRIVER_VER, DRIVER_ID,
                                     s_q.sel};
                    end
                sensor_param_pkg::INFO1_A:
                    if (present) begin
                        s_d.rdata = {RESOLUTION,
                                     mbus.rdata[63:48]};
                    end
                sensor_param_pkg::INFO2_A:
                    if (present) begin
                        s_d.rdata = {MIN_RATE, MAX_RATE,
                                     POWER_TENTHS};
                    end
                sensor_param_pkg::INFO3_A:
                    if (present) begin
                        s_d.rdata = {fifo_max,
                            sensor_param_pkg::RESERVED_EVENTS};
                    end
                sensor_param_pkg::INFO4_A:
                    if (present) begin
                        s_d.rdata = {24'h00_0000, sbytes};
                    end
                sensor_param_pkg::STATUS_A:
                    if (present) begin
                        s_d.rdata = {24'h00_0000, 1'b0, pm,
                                     s_q.flg[s_q.sel[5:0]]};
                    end
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes take effect at the access edge
        if (wr) begin
            unique case (PADDR)
                sensor_param_pkg::SEL_A:
                    s_d.sel = PWDATA[7:0];
                sensor_param_pkg::RATELAT_A:
                    s_d.stage = PWDATA;
                sensor_param_pkg::SENSRNG_A:
                    if (present) begin
                        s_d.en[s_q.sel[5:0]] =
                            (s_q.stage[15:0] != 16'h0000);
                        s_d.bat[s_q.sel[5:0]] =
                            (s_q.stage[31:16] != 16'h0000);
                    end
                sensor_param_pkg::FLUSH_A:
                    // A second request while one drains is dropped
                    if (s_q.fst == sensor_param_pkg::FL_IDLE
                        && PWDATA[7:0] != sensor_param_pkg::FLUSH_NOP) begin
                        s_d.flush  = PWDATA[7:0];
                        s_d.fst    = sensor_param_pkg::FL_DRAIN;
                        s_d.fwake  = (PWDATA[7:0] ==
                            sensor_param_pkg::FLUSH_ALL)
                            || PWDATA[sensor_param_pkg::WAKE_BIT];
                        s_d.fnwake = (PWDATA[7:0] ==
                            sensor_param_pkg::FLUSH_ALL)
                            || !PWDATA[sensor_param_pkg::WAKE_BIT];
                    end
                sensor_param_pkg::STATUS_A:
                    if (present) begin
                        s_d.flg[s_q.sel[5:0]] =
                            s_q.flg[s_q.sel[5:0]] & ~PWDATA[4:0];
                    end
                default: ;
            endcase
        end

        // Flag events after the clear, so a same-cycle set survives
        if (STAT_VALID) begin
            s_d.flg[STAT_ID] = s_d.flg[STAT_ID] | STAT_SET;
        end

        // Route samples of enabled sensors by the wakeup bit
        if (SMP_VALID && s_q.en[SMP_ID]) begin
            s_d.wpush = SMP_ID[sensor_param_pkg::WAKE_BIT];
            s_d.npush = !SMP_ID[sensor_param_pkg::WAKE_BIT];
            s_d.irq   = SMP_ID[sensor_param_pkg::WAKE_BIT]
                        && !s_q.bat[SMP_ID];
        end
        if (EXPIRE_VALID && EXPIRE_ID[sensor_param_pkg::WAKE_BIT]
            && s_q.bat[EXPIRE_ID]) begin
            s_d.irq = 1'b1;
        end

        // Drain finished: queue the completion event once
        if (s_q.fst == sensor_param_pkg::FL_DRAIN && FLUSH_DONE) begin
            s_d.meta    = 1'b1;
            s_d.meta_id = s_q.flush;
            s_d.flush   = sensor_param_pkg::FLUSH_NOP;
            s_d.fst     = sensor_param_pkg::FL_IDLE;
            s_d.fwake   = 1'b0;
            s_d.fnwake  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // All-zero reset: idle flush, no sensors enabled, no flags
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign PRDATA        = s_q.rdata;
    assign PREADY        = 1'b1;
    assign PSLVERR       = PSEL && PENABLE && s_q.err;
    assign WAKE_PUSH     = s_q.wpush;
    assign NWAKE_PUSH    = s_q.npush;
    assign HOST_WAKE_REQ = s_q.irq;
    assign FLUSH_REQ     = (s_q.fst == sensor_param_pkg::FL_DRAIN);
    assign FLUSH_ID      = s_q.flush;
    assign FLUSH_WAKE    = s_q.fwake;
    assign FLUSH_NWAKE   = s_q.fnwake;
    assign META_VALID    = s_q.meta;
    assign META_ID       = s_q.meta_id;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    disabled_no_push_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (SMP_VALID && !s_q.en[SMP_ID] && !$past(SMP_VALID))
        |=> !WAKE_PUSH && !NWAKE_PUSH)
        else $error("disabled sensor sample was pushed");

    wake_fifo_route_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (SMP_VALID && s_q.en[SMP_ID] && SMP_ID[5])
        |=> WAKE_PUSH && !NWAKE_PUSH)
        else $error("wakeup sample not in wakeup fifo");

    nonwake_no_irq_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !((SMP_VALID && SMP_ID[5]) || (EXPIRE_VALID && EXPIRE_ID[5]))
        |=> !HOST_WAKE_REQ)
        else $error("interrupt without a wakeup cause");

    flush_meta_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (FLUSH_REQ && FLUSH_DONE)
        |=> META_VALID && META_ID == $past(FLUSH_ID) && !FLUSH_REQ
            ##1 !META_VALID)
        else $error("flush completion event missing");

    flush_all_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (wr && PADDR == sensor_param_pkg::FLUSH_A && !FLUSH_REQ
         && PWDATA[7:0] == sensor_param_pkg::FLUSH_ALL)
        |=> FLUSH_REQ && FLUSH_WAKE && FLUSH_NWAKE)
        else $error("flush-all did not cover both fifos");

    absent_write_drop_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!present && s_q.sel[7:6] == 2'b00) |=> mbus.rdata == 64'h0)
        else $error("config stored for an absent sensor");

    absent_readback_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (setup && !PWRITE && PADDR == sensor_param_pkg::RATELAT_A
         && !present) |=> PRDATA == 32'h0000_0000)
        else $error("absent sensor rate/latency not zero");

    reserved_zero_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (setup && PADDR == sensor_param_pkg::INFO3_A)
        |=> PRDATA[15:0] == 16'h0000)
        else $error("reserved event count not zero");

endmodule

// File: drain_model.sv
// FIFO engine stand-in that drains the FIFOs on a flush request
// Assumes the bank's clock and synchronous active-low reset
`timescale 1ns/1ns
module drain_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Flush handshake
    input  wire logic       flush_req,
    input  wire logic [3:0] lag,
    output logic            flush_done
);
    logic [3:0] cnt_q;
    // Done after lag plus one pending cycles; one cycle only, so never kinder
    always_ff @(posedge clk) begin
        if (!rst_n || !flush_req || flush_done) begin
            cnt_q      <= 4'h0;
            flush_done <= 1'b0;
        end else begin
            cnt_q      <= cnt_q + 4'h1;
            flush_done <= (cnt_q == lag);
        end
    end
endmodule

// File: sensor_param_config_bench.sv
// Self-checking bench for the sensor parameter bank
// Assumes zero-wait APB and a drain model on the flush handshake
`timescale 1ns/1ns
module sensor_param_config_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        smp_valid = 1'b0;
    logic [5:0]  smp_id = 6'h00;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  lag = 4'h0;
    logic        xp_valid = 1'b0;
    logic        stat_valid = 1'b0;
    logic [5:0]  xp_id = 6'h00;
    logic [5:0]  stat_id = 6'h00;
    logic [4:0]  stat_set = 5'h00;
    logic [31:0] prdata, rd, seed = 32'hd7c14bb9;
    logic        pready, pslverr, err, wpush, npush, irq, freq, fwake;
    logic        fnwake, done, meta;
    logic [7:0]  fid, meta_id;
    int          err_total = 0;
    int          check_count = 0;

    sensor_param_bank dut (
        .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SMP_VALID(smp_valid),
        .SMP_ID(smp_id), .EXPIRE_VALID(xp_valid), .EXPIRE_ID(xp_id),
        .WAKE_PUSH(wpush), .NWAKE_PUSH(npush), .HOST_WAKE_REQ(irq),
        .STAT_VALID(stat_valid), .STAT_ID(stat_id), .STAT_SET(stat_set),
        .FLUSH_REQ(freq), .FLUSH_ID(fid), .FLUSH_WAKE(fwake),
        .FLUSH_NWAKE(fnwake), .FLUSH_DONE(done), .META_VALID(meta),
        .META_ID(meta_id));
    drain_model far (.clk(clk), .rst_n(rst_n), .flush_req(freq),
        .lag(lag), .flush_done(done));

    // ------------------------------------------------------------
    // Clock, helpers and bus master
    // ------------------------------------------------------------
    initial forever #5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Applied rate: next power of two at or above the request
    function automatic logic [15:0] p2(input logic [15:0] r);
        logic [16:0] p;
        p = 17'h1;
        if (r == 16'h0) return 16'h0;
        while (p < {1'b0, r}) p = p << 1;
        return p[15:0];
    endfunction

    task automatic chk(input logic [31:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1, "no ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog: whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence; sb is sample bytes, zero marks an absent id
    // ------------------------------------------------------------
    initial begin
        int ids[5] = '{1, 33, 0, 6, 38};
        int sb[5] = '{8, 8, 0, 4, 4};
        int se[5] = '{2, 5, 0, 0, 4};
        logic [7:0] fl[3] = '{8'hff, 8'd33, 8'd1};
        logic [1:0] fx[3] = '{2'h3, 2'h2, 2'h1};
        logic [15:0] rt[5], lt[5];
        logic [4:0] fs;
        int n;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        lag <= 4'(rnd());
        foreach (ids[i]) begin
            rt[i] = (ids[i] == 6) ? 16'h0 : 16'(rnd() % 32'h8000) + 16'h1;
            lt[i] = (ids[i] == 1 || ids[i] == 38)
                    ? 16'(rnd()) | 16'h1 : 16'h0;
            apb(1'b1, sensor_param_pkg::SEL_A, 32'(ids[i]));
            apb(1'b1, sensor_param_pkg::RATELAT_A, {lt[i], rt[i]});
            apb(1'b1, sensor_param_pkg::SENSRNG_A, 32'h0100_0002);
        end
        // Read-back after all writes shows per-instance storage
        foreach (ids[i]) begin
            apb(1'b1, sensor_param_pkg::SEL_A, 32'(ids[i]));
            apb(1'b0, sensor_param_pkg::RATELAT_A, 32'h0);
            chk(rd, sb[i] ? {lt[i], p2(rt[i])} : 0, "rate");
            apb(1'b0, sensor_param_pkg::SENSRNG_A, 32'h0);
            chk(rd, sb[i] ? 32'h0100_0002 : 0, "range");
            n = !sb[i] ? 0 : rt[i] == 16'h0 ? 1 : rt[i] <= 16'h32 ? 2 : 3;
            apb(1'b0, sensor_param_pkg::STATUS_A, 32'h0);
            chk(rd, 32'(n) << 5, "power mode");
            apb(1'b0, sensor_param_pkg::INFO3_A, 32'h0);
            chk(rd, sb[i] ? (4096 / sb[i]) << 16 : 0, "fifo");
            apb(1'b0, sensor_param_pkg::INFO4_A, 32'h0);
            chk(rd, 32'(sb[i]), "sample size");
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        // Routing and wake requests, disabled and absent ids silent
        foreach (ids[i]) begin
            @(posedge clk);
            smp_valid <= 1'b1;
            smp_id <= 6'(ids[i]);
            @(posedge clk);
            smp_valid <= 1'b0;
            xp_valid <= 1'b1;
            xp_id <= 6'(ids[i]);
            @(posedge clk);
            xp_valid <= 1'b0;
            chk(32'({wpush, npush, irq}), se[i], "route");
            @(posedge clk);
            chk(32'(irq), 32'(ids[i] > 32 && lt[i] != 0), "expiry");
        end
        // Flag event shows in the status word; writing ones clears it
        fs = 5'(rnd()) | 5'h10;
        @(posedge clk);
        stat_valid <= 1'b1;
        stat_id <= 6'h01;
        stat_set <= fs;
        @(posedge clk);
        stat_valid <= 1'b0;
        apb(1'b1, sensor_param_pkg::SEL_A, 32'h1);
        n = rt[0] <= 16'h32 ? 2 : 3;
        apb(1'b0, sensor_param_pkg::STATUS_A, 32'h0);
        chk(rd, 32'(n) << 5 | 32'(fs), "flags set");
        apb(1'b1, sensor_param_pkg::STATUS_A, 32'h1f);
        apb(1'b0, sensor_param_pkg::STATUS_A, 32'h0);
        chk(rd, 32'(n) << 5, "flags clear");
        apb(1'b1, sensor_param_pkg::FLUSH_A, 32'h0);
        @(posedge clk);
        chk(32'(freq), 32'h0, "nop flush");
        foreach (fl[i]) begin
            apb(1'b1, sensor_param_pkg::FLUSH_A, 32'(fl[i]));
            @(posedge clk);
            chk(32'({freq, fwake, fnwake, fid}), {1'b1, fx[i], fl[i]},
                "req");
            n = 0;
            while (meta !== 1'b1 && n < 40) begin
                @(posedge clk);
                n++;
            end
            chk(32'({meta, meta_id}), {1'b1, fl[i]}, "meta");
        end
        final_report();
    end
endmodule
